// [logic/mcd_decoder.sv]
`timescale 1ns/1ps
`default_nettype none
module mcd_decoder #(
    parameter logic [7:0] MODULE_ADDR = 8'h01, // own target address
    parameter int FW_REV = 145, // firmware revision times 100
    parameter int NIRQ = 8 // interrupt sources 0..NIRQ-1
) (
    input wire logic clk_sys, // system clock, 200 MHz
    input wire logic resetn, // async reset, active low
    input wire mcd_pkg::mcd_byte_t rx_byte, // received frame byte
    output logic rx_ready, // decoder can take a byte
    output mcd_pkg::mcd_reply_t reply, // reply pulse
    output mcd_pkg::mcd_par_t par_wr, // axis parameter write pulse
    output logic vel_mode, // velocity mode selected
    output logic dir_left, // last rotate was leftwards
    output logic ext_cmd, // extended opcode accepted, pulse
    input wire logic [NIRQ-1:0] irq_src, // interrupt events, pulses
    input wire mcd_pkg::mcd_ctx_t ctx_in, // live program context
    output logic irq_take, // handler entry pulse
    output logic [7:0] irq_num, // number of taken interrupt
    output logic in_handler, // handler executing
    output logic ctx_restore, // restore pulse on return
    output mcd_pkg::mcd_ctx_t ctx_saved // saved program context
);
    import mcd_pkg::*;

    // extended opcodes only exist from the qualifying revision on
    localparam logic EXT_OK = (FW_REV >= FW_REV_EXTENDED);

    mcd_state_t state_reg, state_next; // frame sequencer
    logic [7:0] frame_reg [FRAME_LEN]; // captured frame bytes
    logic [7:0] frame_next [FRAME_LEN];
    logic [3:0] cnt_reg, cnt_next; // byte position in frame
    logic [7:0] sum_reg, sum_next; // running checksum
    mcd_reply_t reply_reg, reply_next;
    mcd_par_t par_reg, par_next;
    logic vel_reg, vel_next;
    logic left_reg, left_next;
    logic ext_reg, ext_next;
    logic [NIRQ-1:0] vec_reg, vec_next; // handler vector assigned
    logic [NIRQ-1:0] en_reg, en_next; // per-interrupt enable
    logic glob_reg, glob_next; // global interrupt enable
    logic do_return; // return command executes this cycle
    logic [31:0] value; // frame value, msb first
    logic [7:0] op; // frame opcode
    logic [7:0] itype; // frame type byte
    logic recog_ext; // opcode is a recognised extended one
    logic rdy_reg, rdy_next; // take-ready, from a flop like every output

    assign op = frame_reg[IDX_OP];
    assign itype = frame_reg[IDX_TYPE];
    // value bytes arrive most significant first
    assign value = {frame_reg[4], frame_reg[5], frame_reg[6],
        frame_reg[7]};

    // opcode classes of the extended command set
    always_comb begin
        recog_ext = 1'b0;
        if (op >= OP_CALC_FIRST && op <= OP_CALC_LAST) begin
            recog_ext = 1'b1;
        end else if (op == OP_MOVE_ACCU_POS || op == OP_RESTART
            || op == OP_DEC_BRANCH || op == OP_COND_CALL
            || op == OP_ROT_LEFT_ACCU || op == OP_ROT_RIGHT_ACCU) begin
            recog_ext = 1'b1;
        end else if (op >= OP_SET_IDX_VAR && op <= OP_ACCU_IDX_VAR) begin
            recog_ext = 1'b1;
        end
        recog_ext = recog_ext & EXT_OK;
    end

    // frame collection and command execution, next values
    always_comb begin
        state_next = state_reg;
        frame_next = frame_reg;
        cnt_next = cnt_reg;
        sum_next = sum_reg;
        reply_next = '0;
        par_next = '0;
        vel_next = vel_reg;
        left_next = left_reg;
        ext_next = 1'b0;
        vec_next = vec_reg;
        en_next = en_reg;
        glob_next = glob_reg;
        do_return = 1'b0;
        unique case (state_reg)
            S_COLLECT: begin
                if (rx_byte.valid) begin
                    frame_next[cnt_reg] = rx_byte.data;
                    if (cnt_reg == IDX_SUM) begin
                        // keep the sum of the eight data bytes for the check
                        cnt_next = '0;
                        state_next = S_MODE;
                    end else begin
                        cnt_next = cnt_reg + 4'h1;
                        sum_next = sum_reg + rx_byte.data;
                    end
                end
            end
            S_MODE: begin
                state_next = S_COLLECT;
                sum_next = '0; // fresh sum for the next frame
                reply_next.opcode = op;
                if (frame_reg[IDX_ADDR] != MODULE_ADDR) begin
                    // another node's frame: drop silently
                    reply_next.valid = 1'b0;
                end else if (sum_reg != frame_reg[IDX_SUM]) begin
                    reply_next.valid = 1'b1;
                    reply_next.status = ST_BAD_SUM;
                end else if (op == OP_ROT_RIGHT || op == OP_ROT_LEFT
                    || op == OP_HALT) begin
                    // mode first, parameter write in the next cycle
                    vel_next = 1'b1;
                    state_next = S_WRITE;
                end else begin
                    reply_next.valid = 1'b1;
                    reply_next.status = ST_OK;
                    if (op == OP_SET_VECTOR && itype < NIRQ) begin
                        vec_next[itype[2:0]] = 1'b1;
                    end else if (op == OP_INT_ENABLE
                        || op == OP_INT_DISABLE) begin
                        if (itype == IRQ_GLOBAL) begin
                            glob_next = (op == OP_INT_ENABLE);
                        end else if (itype < NIRQ) begin
                            en_next[itype[2:0]] = (op == OP_INT_ENABLE);
                        end
                    end else if (op == OP_RETURN_HANDLER) begin
                        do_return = 1'b1;
                    end else if (op == OP_SET_GLOBAL) begin
                        // bank 3 settings belong to the timer logic
                        reply_next.status = ST_OK;
                    end else if (recog_ext) begin
                        ext_next = 1'b1;
                    end else begin
                        reply_next.status = ST_BAD_CMD;
                    end
                end
            end
            S_WRITE: begin
                state_next = S_COLLECT;
                par_next.valid = 1'b1;
                if (op == OP_HALT) begin
                    par_next.index = PAR_TARGET_SPEED;
                    par_next.value = '0;
                end else begin
                    // signed microsteps per second, passed as is
                    par_next.index = PAR_TARGET_VEL;
                    par_next.value = value;
                    left_next = (op == OP_ROT_LEFT);
                end
                reply_next.valid = 1'b1;
                reply_next.status = ST_OK;
                reply_next.opcode = op;
            end
            default: state_next = S_COLLECT;
        endcase
        // ready follows the state that the coming edge will load
        rdy_next = (state_next == S_COLLECT);
    end

    // frame group registers
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_reg <= S_COLLECT;
            rdy_reg <= 1'b1;
            for (int i = 0; i < FRAME_LEN; i++) begin
                frame_reg[i] <= 8'h00;
            end
            cnt_reg <= 4'h0;
            sum_reg <= 8'h00;
            reply_reg <= '0;
            par_reg <= '0;
            vel_reg <= 1'b0;
            left_reg <= 1'b0;
            ext_reg <= 1'b0;
            vec_reg <= '0;
            en_reg <= '0;
            glob_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            rdy_reg <= rdy_next;
            frame_reg <= frame_next;
            cnt_reg <= cnt_next;
            sum_reg <= sum_next;
            reply_reg <= reply_next;
            par_reg <= par_next;
            vel_reg <= vel_next;
            left_reg <= left_next;
            ext_reg <= ext_next;
            vec_reg <= vec_next;
            en_reg <= en_next;
            glob_reg <= glob_next;
        end
    end

    // interrupt group: sticky pending, arbitration, context
    logic [NIRQ-1:0] pend_reg, pend_next;
    logic hand_reg, hand_next;
    logic take_reg, take_next;
    logic rest_reg, rest_next;
    logic [7:0] num_reg, num_next;
    mcd_ctx_t ctx_reg, ctx_next;
    logic [NIRQ-1:0] ready_irq; // serviceable sources

    always_comb begin
        pend_next = pend_reg | irq_src;
        hand_next = hand_reg;
        take_next = 1'b0;
        rest_next = 1'b0;
        num_next = num_reg;
        ctx_next = ctx_reg;
        ready_irq = pend_reg & vec_reg & en_reg;
        if (do_return && hand_reg) begin
            hand_next = 1'b0;
            rest_next = 1'b1;
        end else if (!hand_reg && glob_reg && ready_irq != '0) begin
            // lowest number wins; others wait, no nesting
            for (int i = NIRQ - 1; i >= 0; i--) begin
                if (ready_irq[i]) begin
                    num_next = 8'(i);
                end
            end
            hand_next = 1'b1;
            take_next = 1'b1;
            ctx_next = ctx_in;
            // a new event in the same cycle re-arms the flag
            pend_next[num_next[2:0]] = irq_src[num_next[2:0]];
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pend_reg <= '0;
            hand_reg <= 1'b0;
            take_reg <= 1'b0;
            rest_reg <= 1'b0;
            num_reg <= 8'h00;
            ctx_reg <= '0;
        end else begin
            pend_reg <= pend_next;
            hand_reg <= hand_next;
            take_reg <= take_next;
            rest_reg <= rest_next;
            num_reg <= num_next;
            ctx_reg <= ctx_next;
        end
    end

    assign rx_ready = rdy_reg;
    assign reply = reply_reg;
    assign par_wr = par_reg;
    assign vel_mode = vel_reg;
    assign dir_left = left_reg;
    assign ext_cmd = ext_reg;
    assign irq_take = take_reg;
    assign irq_num = num_reg;
    assign in_handler = hand_reg;
    assign ctx_restore = rest_reg;
    assign ctx_saved = ctx_reg;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    a_rotate_velocity: assert property ((state_reg == S_WRITE
        && op == OP_ROT_RIGHT) |=> par_reg.valid && vel_reg
        && par_reg.index == PAR_TARGET_VEL && !left_reg)
        else $error("right rotate did not write target velocity");
    a_left_dir: assert property ((state_reg == S_WRITE
        && op == OP_ROT_LEFT) |=> left_reg && par_reg.value ==
        $past(value)) else $error("left rotate direction wrong");
    a_halt_zero: assert property ((state_reg == S_WRITE
        && op == OP_HALT) |=> par_reg.index == PAR_TARGET_SPEED
        && par_reg.value == 32'h0000_0000)
        else $error("halt did not zero target speed");
    a_mode_first: assert property ($rose(par_reg.valid) |->
        $past(vel_reg)) else $error("parameter written before mode");
    a_ok_status: assert property (par_reg.valid |->
        reply_reg.valid && reply_reg.status == ST_OK)
        else $error("motion command not answered with success");
    a_sum_reject: assert property ((state_reg == S_MODE
        && frame_reg[IDX_ADDR] == MODULE_ADDR
        && sum_reg != frame_reg[IDX_SUM]) |=>
        reply_reg.status == ST_BAD_SUM && !par_reg.valid ##1
        !par_reg.valid) else $error("bad checksum accepted");
    a_take_gated: assert property (take_next |-> glob_reg
        && vec_reg[num_next[2:0]] && en_reg[num_next[2:0]])
        else $error("interrupt taken without enables");
    a_no_nesting: assert property (hand_reg |-> !take_next)
        else $error("nested interrupt entry");
    a_ctx_saved: assert property ($rose(hand_reg) |->
        ctx_reg == $past(ctx_in)) else $error("context not saved");
    a_ctx_restore: assert property ((do_return && hand_reg) |=>
        ctx_restore && !in_handler) else $error("return did not restore");
    a_ext_gate: assert property (ext_reg |-> EXT_OK)
        else $error("extended opcode on old revision");

    c_rotate: cover property (par_reg.valid && left_reg);
    c_halt: cover property (par_reg.valid
        && par_reg.index == PAR_TARGET_SPEED);
    c_irq_cycle: cover property (irq_take ##[1:200] ctx_restore);
    c_bad_sum: cover property (reply_reg.status == ST_BAD_SUM);
endmodule : mcd_decoder
`default_nettype wire

// [logic/mcd_pkg.sv]
package mcd_pkg;
    // frame layout: address, opcode, type, bank, value msb..lsb, checksum
    localparam int FRAME_LEN = 9;
    localparam logic [3:0] IDX_ADDR = 4'h0;
    localparam logic [3:0] IDX_OP = 4'h1;
    localparam logic [3:0] IDX_TYPE = 4'h2;
    localparam logic [3:0] IDX_BANK = 4'h3;
    localparam logic [3:0] IDX_SUM = 4'h8;
    // opcodes
    localparam logic [7:0] OP_ROT_RIGHT = 8'h01;
    localparam logic [7:0] OP_ROT_LEFT = 8'h02;
    localparam logic [7:0] OP_HALT = 8'h03;
    localparam logic [7:0] OP_SET_GLOBAL = 8'h09;
    localparam logic [7:0] OP_INT_ENABLE = 8'h19;
    localparam logic [7:0] OP_INT_DISABLE = 8'h1A;
    localparam logic [7:0] OP_SET_VECTOR = 8'h25;
    localparam logic [7:0] OP_RETURN_HANDLER = 8'h26;
    localparam logic [7:0] OP_CALC_FIRST = 8'h28;
    localparam logic [7:0] OP_CALC_LAST = 8'h2D;
    localparam logic [7:0] OP_MOVE_ACCU_POS = 8'h2E;
    localparam logic [7:0] OP_RESTART = 8'h30;
    localparam logic [7:0] OP_DEC_BRANCH = 8'h31;
    localparam logic [7:0] OP_ROT_LEFT_ACCU = 8'h32;
    localparam logic [7:0] OP_ROT_RIGHT_ACCU = 8'h33;
    localparam logic [7:0] OP_SET_IDX_VAR = 8'h37;
    localparam logic [7:0] OP_ACCU_IDX_VAR = 8'h39;
    localparam logic [7:0] OP_COND_CALL = 8'h50;
    // axis parameters and special numbers
    localparam logic [7:0] PAR_TARGET_SPEED = 8'h00;
    localparam logic [7:0] PAR_TARGET_VEL = 8'h02;
    localparam logic [7:0] IRQ_GLOBAL = 8'hFF;
    localparam logic [7:0] BANK_IRQ_CFG = 8'h03;
    localparam int FW_REV_EXTENDED = 145;
    // reply status codes
    localparam logic [7:0] ST_OK = 8'h64;
    localparam logic [7:0] ST_BAD_SUM = 8'h01;
    localparam logic [7:0] ST_BAD_CMD = 8'h02;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } mcd_byte_t;

    typedef struct packed {
        logic valid;
        logic [7:0] status;
        logic [7:0] opcode;
    } mcd_reply_t;

    typedef struct packed {
        logic valid;
        logic [7:0] index;
        logic [31:0] value;
    } mcd_par_t;

    typedef struct packed {
        logic [31:0] accu;
        logic [31:0] x;
        logic [3:0] flags;
    } mcd_ctx_t;

    typedef enum logic [1:0] {
        S_COLLECT = 2'b00,
        S_MODE = 2'b01,
        S_WRITE = 2'b10
    } mcd_state_t;
endpackage : mcd_pkg

// [verification/mcd_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module mcd_host_model (
    input wire logic clk_sys, // system clock
    input wire logic rx_ready, // decoder takes bytes
    output var mcd_pkg::mcd_byte_t rx_byte // byte towards decoder
);
    import mcd_pkg::*;
    logic rdy_q; // ready as seen before the coming edge
    initial rx_byte = '0;
    // sample ready away from the edge so a take is judged without a race
    always @(negedge clk_sys) rdy_q = rx_ready;
    // one whole frame; bad spoils the sum on purpose
    task automatic send(input logic [7:0] adr, op, typ, bnk,
                        input logic [31:0] val, input logic bad);
        logic [7:0] f [9];
        int i;
        f = '{adr, op, typ, bnk, val[31:24], val[23:16], val[15:8],
              val[7:0], 8'h00};
        for (i = 0; i < 8; i++) f[8] = f[8] + f[i];
        if (bad) f[8] = f[8] ^ 8'h5A;
        // hold each byte until an edge where ready was high
        for (i = 0; i < 9; i++) begin
            rx_byte <= '{valid: 1'b1, data: f[i]};
            @(posedge clk_sys);
            while (!rdy_q) @(posedge clk_sys);
        end
        // a released line must not keep showing the last byte
        rx_byte <= '{valid: 1'b0, data: ~f[8]};
    endtask : send
endmodule : mcd_host_model
`default_nettype wire

// [verification/test_motion_command_decoder.sv]
`timescale 1ns/1ps
`default_nettype none
module test_motion_command_decoder;
    import mcd_pkg::*;
    logic clk_sys = 1'b0; // 200 MHz system clock
    logic resetn = 1'b0; // active low reset
    mcd_byte_t rx_byte; // from the host model
    logic rx_ready, vel_mode, dir_left, ext_cmd, irq_take; // dut levels and pulses
    logic in_handler, ctx_restore; // handler state
    logic [7:0] irq_num; // last taken number
    logic [7:0] irq_src = 8'h00; // interrupt events
    mcd_reply_t reply; // reply pulse
    mcd_par_t par_wr; // parameter write pulse
    mcd_ctx_t ctx_in = '{32'h11223344, 32'h55667788, 4'hA}; // live ctx
    mcd_ctx_t ctx_saved; // captured ctx
    mcd_reply_t rep_q; // last reply seen
    mcd_par_t par_q; // parameter write seen with it
    logic got_rep = 1'b0; // reply arrived
    logic exp_dir = 1'b0; // expected direction level
    int fails = 0, n_tests = 0, n_par = 0, n_ext = 0, n_take = 0, n_rest = 0;
    logic [7:0] ext_ops [15] = '{8'h28, 8'h29, 8'h2A, 8'h2B, 8'h2C,
        8'h2D, 8'h2E, 8'h30, 8'h31, 8'h32, 8'h33, 8'h37, 8'h38, 8'h39,
        8'h50}; // every extended opcode

    always #2.5 clk_sys = ~clk_sys;

    mcd_host_model host_u (.clk_sys(clk_sys), .rx_ready(rx_ready),
        .rx_byte(rx_byte));
    mcd_decoder dut_u (.clk_sys(clk_sys), .resetn(resetn),
        .rx_byte(rx_byte), .rx_ready(rx_ready), .reply(reply),
        .par_wr(par_wr), .vel_mode(vel_mode), .dir_left(dir_left),
        .ext_cmd(ext_cmd), .irq_src(irq_src), .ctx_in(ctx_in),
        .irq_take(irq_take), .irq_num(irq_num), .in_handler(in_handler),
        .ctx_restore(ctx_restore), .ctx_saved(ctx_saved));

    // pulses are caught in their one cycle, before the edge updates land
    always @(posedge clk_sys) begin
        if (reply.valid) begin
            got_rep = 1'b1;
            rep_q = reply;
            par_q = par_wr;
        end
        if (par_wr.valid) n_par++;
        if (ext_cmd) n_ext++;
        if (irq_take) n_take++;
        if (ctx_restore) n_rest++;
    end

    task automatic chk(input logic [67:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
            fails++;
        end
    endtask : chk

    // one frame to our address, then a bounded wait for the answer
    task automatic cmd(input logic [7:0] op, typ, bnk,
                       input logic [31:0] val, input logic bad);
        got_rep = 1'b0;
        rep_q = '0; // a missing reply must not reuse a stale status
        host_u.send(8'h01, op, typ, bnk, val, bad);
        repeat (8) if (!got_rep) @(posedge clk_sys);
    endtask : cmd

    task automatic pulse(input logic [7:0] src);
        irq_src <= src;
        @(posedge clk_sys);
        irq_src <= 8'h00;
    endtask : pulse

    task automatic t_refuse;
        n_par = 0;
        cmd(OP_ROT_RIGHT, 8'h00, 8'h00, 32'h00001000, 1'b1);
        chk(rep_q.status, ST_BAD_SUM);
        chk(n_par + vel_mode, 0);
        got_rep = 1'b0;
        host_u.send(8'h02, OP_HALT, 8'h00, 8'h00, 32'h0, 1'b0);
        repeat (8) @(posedge clk_sys);
        chk(got_rep, 1'b0);
    endtask : t_refuse

    task automatic t_motion(input logic [7:0] op, input logic [31:0] v);
        n_par = 0;
        if (op != OP_HALT) exp_dir = (op == OP_ROT_LEFT);
        cmd(op, 8'h00, 8'h00, v, 1'b0);
        chk({rep_q.status, rep_q.opcode}, {ST_OK, op});
        chk({n_par[1:0], par_q}, {2'h1, 1'b1, (op == OP_HALT) ?
            {PAR_TARGET_SPEED, 32'h0} : {PAR_TARGET_VEL, v}});
        chk({vel_mode, dir_left}, {1'b1, exp_dir});
    endtask : t_motion

    task automatic t_ext;
        int i;
        for (i = 0; i < 15; i++) begin
            n_ext = 0;
            cmd(ext_ops[i], 8'h00, 8'h00, 32'h0, 1'b0);
            chk({rep_q.status, n_ext[1:0]}, {ST_OK, 2'h1});
        end
        n_ext = 0;
        cmd(8'h2F, 8'h00, 8'h00, 32'h0, 1'b0);
        chk({rep_q.status, n_ext[1:0]}, {ST_BAD_CMD, 2'h0});
    endtask : t_ext

    task automatic t_irq;
        mcd_ctx_t first_ctx;
        first_ctx = ctx_in;
        cmd(OP_SET_VECTOR, 8'h02, 8'h00, 32'h10, 1'b0);
        cmd(OP_SET_VECTOR, 8'h05, 8'h00, 32'h20, 1'b0);
        cmd(OP_SET_GLOBAL, 8'h02, BANK_IRQ_CFG, 32'd1000, 1'b0);
        chk(rep_q.status, ST_OK);
        cmd(OP_INT_ENABLE, 8'h02, 8'h00, 32'h0, 1'b0);
        cmd(OP_INT_ENABLE, 8'h05, 8'h00, 32'h0, 1'b0);
        pulse(8'h04);
        repeat (12) @(posedge clk_sys);
        chk(n_take, 0);
        cmd(OP_INT_ENABLE, IRQ_GLOBAL, 8'h00, 32'h0, 1'b0);
        repeat (20) if (n_take < 1) @(posedge clk_sys);
        @(posedge clk_sys);
        chk({n_take[1:0], irq_num, in_handler}, {2'h1, 8'h02, 1'b1});
        chk(ctx_saved, first_ctx);
        ctx_in <= '{32'hCAFE0001, 32'h0BAD0002, 4'h5};
        pulse(8'h20);
        repeat (12) @(posedge clk_sys);
        chk(n_take, 1);
        cmd(OP_RETURN_HANDLER, 8'h00, 8'h00, 32'h0, 1'b0);
        repeat (20) if (n_take < 2) @(posedge clk_sys);
        @(posedge clk_sys);
        chk({n_rest[1:0], n_take[1:0], irq_num}, {2'h1, 2'h2, 8'h05});
        chk(ctx_saved, {32'hCAFE0001, 32'h0BAD0002, 4'h5});
        cmd(OP_RETURN_HANDLER, 8'h00, 8'h00, 32'h0, 1'b0);
        repeat (3) @(posedge clk_sys);
        chk({n_rest[1:0], in_handler}, {2'h2, 1'b0});
    endtask : t_irq

    // mid-run reset, then a disabled source must wait with its event held
    task automatic t_reset;
        resetn <= 1'b0;
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        chk({rx_ready, vel_mode, dir_left, in_handler}, 4'h8);
        chk(ctx_saved, '0);
        n_take = 0;
        @(posedge clk_sys);
        cmd(OP_SET_VECTOR, 8'h01, 8'h00, 32'h30, 1'b0);
        cmd(OP_INT_ENABLE, 8'h01, 8'h00, 32'h0, 1'b0);
        cmd(OP_INT_ENABLE, IRQ_GLOBAL, 8'h00, 32'h0, 1'b0);
        cmd(OP_INT_DISABLE, 8'h01, 8'h00, 32'h0, 1'b0);
        chk(rep_q.status, ST_OK);
        pulse(8'h02);
        repeat (12) @(posedge clk_sys);
        chk(n_take, 0);
        cmd(OP_INT_ENABLE, 8'h01, 8'h00, 32'h0, 1'b0);
        repeat (6) @(posedge clk_sys);
        chk({n_take[1:0], irq_num, in_handler},
            {2'h1, 8'h01, 1'b1});
    endtask : t_reset

    task automatic summarize;
        if (fails == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : summarize

    // a hung handshake must still end the run with a verdict
    initial begin
        #(20000 * 5);
        fails++;
        summarize();
    end

    initial begin
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        t_refuse();
        t_motion(OP_ROT_RIGHT, 32'h0000C800);
        t_motion(OP_ROT_LEFT, 32'hFFFFD8F0);
        t_motion(OP_HALT, 32'h0);
        t_ext();
        t_irq();
        t_reset();
        summarize();
    end
endmodule : test_motion_command_decoder
`default_nettype wire
